// ==== src/pscc_cfg.svh ====
// constants for the paper supply and cartridge tag controller: offsets, fields, times
// assumes a 50 MHz clock and a 32-bit Avalon-MM slave with byte addresses
//
// Behaviour
// - read tag: power-on, cover close, command
// - write tag periodically while printing, on command
// - tag failure or bad data: fault, stop printing
// - report cartridge presence from its sensor
// - paper late at path sensor: declare jam
// - separate paper-present bit per source
// - cassette installed if middle or lower switch
// - cassette pickup needs installed, correct media
// - switch groups read top, middle, bottom
// - width 100: letter, ledger, custom decode
// - width 001: executive, custom decode
// - cassette print command raises plate by lift_raise_r
// - lift up at power-on, insertion, job
// - idle after lift-up lowers the plate
// - no tray one without upper cassette
// - tray one pickup needs tray and paper
// - drive main, fuser motors and solenoids
// - top sensor held too long: stationary jam
`ifndef PSCC_CFG_SVH
`define PSCC_CFG_SVH

`define PSCC_CLK_KHZ        50000
`define PSCC_T_PICK_UP_MS   1500
`define PSCC_T_PICK_LO_MS   2800
`define PSCC_T_PICK_MP_MS   1100
`define PSCC_T_STAT_MS      400
`define PSCC_T_FDLY_MS      1500
`define PSCC_T_FSTAT_MS     2300
`define PSCC_T_WRAP_MS      700
`define PSCC_T_TAG_WR_MS    1000
`define PSCC_T_IDLE_MS      30000
`define PSCC_T_SOL_MS       100

`define PSCC_ADDR_CTRL      5'h00
`define PSCC_ADDR_TAGDATA   5'h04
`define PSCC_ADDR_STATUS    5'h08
`define PSCC_ADDR_SIZE      5'h0c
`define PSCC_ADDR_JAM       5'h10

`define PSCC_CTRL_TAG_RD    0
`define PSCC_CTRL_TAG_WR    1
`define PSCC_CTRL_PRINT     2
`define PSCC_CTRL_SRC_LO    4
`define PSCC_CTRL_CLR_JAM   8
`define PSCC_CTRL_CLR_FLT   9

`define PSCC_SRC_MP         2'h0
`define PSCC_SRC_UPPER      2'h1
`define PSCC_SRC_LOWER      2'h2

`define PSCC_JAM_PICK_DLY   0
`define PSCC_JAM_PICK_STAT  1
`define PSCC_JAM_FUSE_DLY   2
`define PSCC_JAM_FUSE_STAT  3
`define PSCC_JAM_WRAP       4
`define PSCC_JAM_DELIV_STAT 5
`define PSCC_NJAM           6

`define PSCC_SW_TOP         2
`define PSCC_SW_MID         1
`define PSCC_SW_BOT         0

`endif

// ==== src/pscc_pkg.sv ====
// types shared by the paper supply and cartridge tag controller
// assumes nothing beyond a SystemVerilog compiler
package pscc_pkg;

	typedef enum logic [3:0] {
		PSCC_SZ_NONE      = 4'h0,
		PSCC_SZ_LETTER    = 4'h1,
		PSCC_SZ_LEDGER    = 4'h2,
		PSCC_SZ_EXECUTIVE = 4'h3,
		PSCC_SZ_CUSTOM    = 4'h4,
		PSCC_SZ_A4        = 4'h5,
		PSCC_SZ_A3        = 4'h6,
		PSCC_SZ_B5        = 4'h7,
		PSCC_SZ_B4        = 4'h8,
		PSCC_SZ_UNKNOWN   = 4'hf
	} pscc_size_t;

	typedef struct packed {
		logic top_of_page_sensor;
		logic prefeed_sensor;
		logic paper_loop_sensor;
		logic fuser_exit_sensor;
		logic bin_full_sensor;
		logic delivery_sensor;
	} pscc_path_t;

	typedef struct packed {
		logic       done;
		logic       fail;
		logic [7:0] rdata;
	} pscc_tag_rsp_t;

	typedef enum logic [3:0] {
		PSCC_LF_DOWN  = 4'h1,
		PSCC_LF_RAISE = 4'h2,
		PSCC_LF_UP    = 4'h4,
		PSCC_LF_LOWER = 4'h8
	} pscc_lift_st_t;

	typedef enum logic [3:0] {
		PSCC_PR_IDLE = 4'h1,
		PSCC_PR_LIFT = 4'h2,
		PSCC_PR_PICK = 4'h4,
		PSCC_PR_FEED = 4'h8
	} pscc_print_st_t;

	typedef enum logic [1:0] {
		PSCC_TG_IDLE = 2'h1,
		PSCC_TG_BUSY = 2'h2
	} pscc_tag_st_t;

endpackage : pscc_pkg

// ==== src/pscc_timer.sv ====
// run-while-level timer: counts while run is high, restarts when run drops
// assumes limit is held steady while run is high
module pscc_timer #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	output logic              expired
);
	initial begin
		if (W < 2 || W > 32) $error("pscc_timer: width out of range");
	end

	logic [W-1:0] cnt_r;

	// expired pulses once per run; a held run does not refire
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r   <= '0;
			expired <= 1'b0;
		end else if (!run) begin
			cnt_r   <= '0;
			expired <= 1'b0;
		end else begin
			expired <= (cnt_r == limit - W'(1));
			if (cnt_r != limit) cnt_r <= cnt_r + W'(1);
		end
	end
endmodule : pscc_timer

// ==== src/pscc_ctl.sv ====
// paper supply and cartridge tag controller: tag access, size decode, lifter, pickup, jams
// assumes synchronous sensor inputs and an Avalon-MM master holding each request
//
// Our own choices: register access over Avalon-MM and the register addresses.
`include "pscc_cfg.svh"
module pscc_ctl #(
	parameter int unsigned T_PICK_UP  = `PSCC_T_PICK_UP_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_PICK_LO  = `PSCC_T_PICK_LO_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_PICK_MP  = `PSCC_T_PICK_MP_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_STAT     = `PSCC_T_STAT_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_FDLY     = `PSCC_T_FDLY_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_FSTAT    = `PSCC_T_FSTAT_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_WRAP     = `PSCC_T_WRAP_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_TAG_WR   = `PSCC_T_TAG_WR_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_IDLE     = `PSCC_T_IDLE_MS * `PSCC_CLK_KHZ,
	parameter int unsigned T_SOL      = `PSCC_T_SOL_MS * `PSCC_CLK_KHZ
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [4:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic                  cover_closed,
	input  wire logic                  cartridge_presence_sensor,
	input  wire logic                  mp_tray_paper_sensor,
	input  wire logic                  mp_tray_closed,
	input  wire logic                  upper_cassette_paper_sensor,
	input  wire logic                  lower_cassette_paper_sensor,
	input  wire logic [2:0]            upper_length_switches,
	input  wire logic [2:0]            lower_length_switches,
	input  wire logic [2:0]            upper_width_switches,
	input  wire logic [2:0]            lower_width_switches,
	input  wire logic                  cassette_media_ok,
	input  wire logic                  upper_lifter_position_sensor,
	input  wire logic                  lower_lifter_position_sensor,
	input  wire pscc_pkg::pscc_path_t  path,
	input  wire pscc_pkg::pscc_tag_rsp_t tag_rsp,
	output logic                       tag_req_r,
	output logic                       tag_we_r,
	output logic [7:0]                 tag_wdata_r,
	output logic                       main_motor_r,
	output logic                       fuser_motor_r,
	output logic                       cassette_pick_sol_r,
	output logic                       cassette_sel_lower_r,
	output logic                       mp_pick_sol_r,
	output logic [1:0]                 lift_raise_r,
	output logic [1:0]                 lift_lower_r,
	output logic                       jam_flag_r,
	output logic                       cart_fault_r
);
	initial begin
		if (T_PICK_UP < 2 || T_PICK_LO < 2 || T_PICK_MP < 2 || T_STAT < 2 || T_FDLY < 2 ||
			T_FSTAT < 2 || T_WRAP < 2 || T_TAG_WR < 2 || T_IDLE < 2 || T_SOL < 2)
			$error("pscc_ctl: timer periods must be at least two cycles");
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// size decode and installation

	function automatic logic inst_of(input logic [2:0] len);
		inst_of = len[`PSCC_SW_MID] | len[`PSCC_SW_BOT];
	endfunction : inst_of

	// index 2 top, 1 middle, 0 bottom; a one means the switch is active
	function automatic pscc_pkg::pscc_size_t size_of(input logic [2:0] wid, input logic [2:0] len);
		size_of = pscc_pkg::PSCC_SZ_UNKNOWN;
		case (len)
			3'h4: begin
				case (wid)
					3'h4: size_of = pscc_pkg::PSCC_SZ_LETTER;
					3'h1: size_of = pscc_pkg::PSCC_SZ_EXECUTIVE;
					3'h7: size_of = pscc_pkg::PSCC_SZ_B5;
					3'h0: size_of = pscc_pkg::PSCC_SZ_A4;
					default: size_of = pscc_pkg::PSCC_SZ_UNKNOWN;
				endcase
			end
			3'h5: begin
				case (wid)
					3'h4, 3'h1, 3'h7, 3'h0: size_of = pscc_pkg::PSCC_SZ_CUSTOM;
					default: size_of = pscc_pkg::PSCC_SZ_UNKNOWN;
				endcase
			end
			3'h6: begin
				case (wid)
					3'h4: size_of = pscc_pkg::PSCC_SZ_LEDGER;
					3'h1: size_of = pscc_pkg::PSCC_SZ_CUSTOM;
					3'h7: size_of = pscc_pkg::PSCC_SZ_B4;
					3'h0: size_of = pscc_pkg::PSCC_SZ_A3;
					default: size_of = pscc_pkg::PSCC_SZ_UNKNOWN;
				endcase
			end
			default: size_of = pscc_pkg::PSCC_SZ_UNKNOWN;
		endcase
	endfunction : size_of

	logic [1:0] inst_r;
	logic [1:0] inst_q_r;
	logic [1:0] lifter_sens;
	logic [1:0] paper_cass;
	logic       pwr_up_r;
	logic       cover_q_r;
	pscc_pkg::pscc_path_t path_q_r;

	assign lifter_sens = {lower_lifter_position_sensor, upper_lifter_position_sensor};
	assign paper_cass  = {lower_cassette_paper_sensor, upper_cassette_paper_sensor};

	// pwr_up_r is high for the first cycle after reset release and starts the power-on tag read
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			inst_r    <= 2'h0;
			inst_q_r  <= 2'h0;
			pwr_up_r  <= 1'b1;
			cover_q_r <= 1'b0;
			path_q_r  <= '0;
		end else begin
			inst_r    <= {inst_of(lower_length_switches), inst_of(upper_length_switches)};
			inst_q_r  <= inst_r;
			pwr_up_r  <= 1'b0;
			cover_q_r <= cover_closed;
			path_q_r  <= path;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// register bus: one wait state, answer on the second edge of a request

	logic        acc_r;
	logic        rd_cmd_r;
	logic        wr_cmd_r;
	logic        prn_cmd_r;
	logic        clr_jam_r;
	logic        clr_flt_r;
	logic [1:0]  src_r;
	logic [7:0]  wdata_reg_r;
	logic [7:0]  expect_r;
	logic [31:0] rd_nxt;
	logic        ctrl_wr;
	logic [`PSCC_NJAM-1:0] jam_r;
	logic        refused_r;
	logic [7:0]  tag_last_r;
	pscc_pkg::pscc_lift_st_t  lf_r [2];
	pscc_pkg::pscc_print_st_t pr_r;
	pscc_pkg::pscc_tag_st_t   tg_r;

	assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == `PSCC_ADDR_CTRL;

	always_comb begin
		rd_nxt = 32'h0;
		case (avs_address)
			`PSCC_ADDR_CTRL:    rd_nxt = {26'h0, src_r, 4'h0};
			`PSCC_ADDR_TAGDATA: rd_nxt = {16'h0, expect_r, wdata_reg_r};
			`PSCC_ADDR_STATUS:  rd_nxt = {12'h0, refused_r, path_q_r.bin_full_sensor, lf_r[1], lf_r[0],
				pr_r != pscc_pkg::PSCC_PR_IDLE, tg_r == pscc_pkg::PSCC_TG_BUSY, cart_fault_r, jam_flag_r,
				inst_r, cartridge_presence_sensor, lower_cassette_paper_sensor,
				upper_cassette_paper_sensor, mp_tray_paper_sensor};
			`PSCC_ADDR_SIZE:    rd_nxt = {16'h0, tag_last_r, size_of(lower_width_switches, lower_length_switches),
				size_of(upper_width_switches, upper_length_switches)};
			`PSCC_ADDR_JAM:     rd_nxt = {{(32-`PSCC_NJAM){1'b0}}, jam_r};
			default:            rd_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
			acc_r           <= 1'b0;
		end else begin
			acc_r           <= (avs_read || avs_write) && avs_waitrequest && !acc_r;
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !acc_r);
			if (avs_read && avs_waitrequest) avs_readdata <= rd_nxt;
		end
	end

	// command bits are one-cycle pulses from a write to the control word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_cmd_r    <= 1'b0;
			wr_cmd_r    <= 1'b0;
			prn_cmd_r   <= 1'b0;
			clr_jam_r   <= 1'b0;
			clr_flt_r   <= 1'b0;
			src_r       <= `PSCC_SRC_UPPER;
			wdata_reg_r <= 8'h0;
			expect_r    <= 8'h0;
		end else begin
			rd_cmd_r  <= ctrl_wr && avs_byteenable[0] && avs_writedata[`PSCC_CTRL_TAG_RD];
			wr_cmd_r  <= ctrl_wr && avs_byteenable[0] && avs_writedata[`PSCC_CTRL_TAG_WR];
			prn_cmd_r <= ctrl_wr && avs_byteenable[0] && avs_writedata[`PSCC_CTRL_PRINT];
			clr_jam_r <= ctrl_wr && avs_byteenable[1] && avs_writedata[`PSCC_CTRL_CLR_JAM];
			clr_flt_r <= ctrl_wr && avs_byteenable[1] && avs_writedata[`PSCC_CTRL_CLR_FLT];
			if (ctrl_wr && avs_byteenable[0]) src_r <= avs_writedata[`PSCC_CTRL_SRC_LO +: 2];
			if (avs_write && !avs_waitrequest && avs_address == `PSCC_ADDR_TAGDATA) begin
				if (avs_byteenable[0]) wdata_reg_r <= avs_writedata[7:0];
				if (avs_byteenable[1]) expect_r <= avs_writedata[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// cartridge memory tag

	logic rd_pend_r;
	logic wr_pend_r;
	logic tag_tick;
	logic tag_bad;
	logic printing;

	assign printing = pr_r != pscc_pkg::PSCC_PR_IDLE;
	// a read must return the software check byte; a write must echo the byte sent
	assign tag_bad  = tag_rsp.fail || (tag_we_r ? tag_rsp.rdata != tag_wdata_r : tag_rsp.rdata != expect_r);

	pscc_timer u_tag_tmr (
		.clk     (clk),
		.reset   (reset),
		.run     (printing && !cart_fault_r && !tag_tick),
		.limit   (T_TAG_WR),
		.expired (tag_tick)
	);

	// new requests win over the clear made by starting an access
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_pend_r <= 1'b0;
			wr_pend_r <= 1'b0;
		end else begin
			if (pwr_up_r || (cover_closed && !cover_q_r) || rd_cmd_r) rd_pend_r <= 1'b1;
			else if (tg_r == pscc_pkg::PSCC_TG_IDLE) rd_pend_r <= 1'b0;
			if (tag_tick || wr_cmd_r) wr_pend_r <= 1'b1;
			else if (tg_r == pscc_pkg::PSCC_TG_IDLE && !rd_pend_r) wr_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tg_r         <= pscc_pkg::PSCC_TG_IDLE;
			tag_req_r    <= 1'b0;
			tag_we_r     <= 1'b0;
			tag_wdata_r  <= 8'h0;
			tag_last_r   <= 8'h0;
			cart_fault_r <= 1'b0;
		end else begin
			case (tg_r)
				pscc_pkg::PSCC_TG_IDLE: begin
					if (rd_pend_r || wr_pend_r) begin
						tg_r        <= pscc_pkg::PSCC_TG_BUSY;
						tag_req_r   <= 1'b1;
						tag_we_r    <= !rd_pend_r;
						tag_wdata_r <= wdata_reg_r;
					end
				end
				pscc_pkg::PSCC_TG_BUSY: begin
					if (tag_rsp.done) begin
						tg_r       <= pscc_pkg::PSCC_TG_IDLE;
						tag_req_r  <= 1'b0;
						tag_last_r <= tag_rsp.rdata;
					end
				end
				default: begin
					tg_r      <= pscc_pkg::PSCC_TG_IDLE;
					tag_req_r <= 1'b0;
				end
			endcase
			if (tg_r == pscc_pkg::PSCC_TG_BUSY && tag_rsp.done && tag_bad) cart_fault_r <= 1'b1;
			else if (clr_flt_r) cart_fault_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// lifting plates, one per cassette

	logic [1:0] idle_exp;
	logic [1:0] job_lift;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_lift
			pscc_timer u_idle (
				.clk     (clk),
				.reset   (reset),
				.run     (lf_r[gi] == pscc_pkg::PSCC_LF_UP && !printing),
				.limit   (T_IDLE),
				.expired (idle_exp[gi])
			);

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					lf_r[gi]         <= pscc_pkg::PSCC_LF_DOWN;
					lift_raise_r[gi] <= 1'b0;
					lift_lower_r[gi] <= 1'b0;
				end else begin
					case (lf_r[gi])
						pscc_pkg::PSCC_LF_DOWN, pscc_pkg::PSCC_LF_LOWER: begin
							if (inst_r[gi] && (pwr_up_r || (inst_r[gi] && !inst_q_r[gi]) || job_lift[gi])) begin
								lf_r[gi]         <= pscc_pkg::PSCC_LF_RAISE;
								lift_raise_r[gi] <= 1'b1;
								lift_lower_r[gi] <= 1'b0;
							end else if (lf_r[gi] == pscc_pkg::PSCC_LF_LOWER && !lifter_sens[gi]) begin
								lf_r[gi]         <= pscc_pkg::PSCC_LF_DOWN;
								lift_lower_r[gi] <= 1'b0;
							end
						end
						pscc_pkg::PSCC_LF_RAISE: begin
							if (lifter_sens[gi] || !inst_r[gi]) begin
								lf_r[gi]         <= lifter_sens[gi] ? pscc_pkg::PSCC_LF_UP : pscc_pkg::PSCC_LF_DOWN;
								lift_raise_r[gi] <= 1'b0;
							end
						end
						pscc_pkg::PSCC_LF_UP: begin
							if (!inst_r[gi])
								lf_r[gi] <= pscc_pkg::PSCC_LF_DOWN;
							else if (idle_exp[gi]) begin
								lf_r[gi]         <= pscc_pkg::PSCC_LF_LOWER;
								lift_lower_r[gi] <= 1'b1;
							end
						end
						default: begin
							lf_r[gi]         <= pscc_pkg::PSCC_LF_DOWN;
							lift_raise_r[gi] <= 1'b0;
							lift_lower_r[gi] <= 1'b0;
						end
					endcase
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////////////////
	// pickup and feed

	logic       src_ok;
	logic       jam_any;
	logic       halt;
	logic       sol_exp;
	logic [1:0] cidx;

	assign cidx = (src_r == `PSCC_SRC_LOWER) ? 2'h1 : 2'h0;
	assign src_ok = (src_r == `PSCC_SRC_MP) ? (inst_r[0] && mp_tray_closed && mp_tray_paper_sensor) :
		(src_r == `PSCC_SRC_UPPER || src_r == `PSCC_SRC_LOWER) &&
		inst_r == 2'h3 && cassette_media_ok && paper_cass[cidx[0]];
	assign jam_any = |jam_r;
	assign halt    = jam_any || cart_fault_r;
	assign job_lift = (prn_cmd_r && pr_r == pscc_pkg::PSCC_PR_IDLE && src_ok && !halt && src_r != `PSCC_SRC_MP) ?
		(cidx[0] ? 2'h2 : 2'h1) : 2'h0;

	pscc_timer u_sol (
		.clk     (clk),
		.reset   (reset),
		.run     (pr_r == pscc_pkg::PSCC_PR_PICK),
		.limit   (T_SOL),
		.expired (sol_exp)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pr_r                 <= pscc_pkg::PSCC_PR_IDLE;
			main_motor_r         <= 1'b0;
			fuser_motor_r        <= 1'b0;
			cassette_pick_sol_r  <= 1'b0;
			cassette_sel_lower_r <= 1'b0;
			mp_pick_sol_r        <= 1'b0;
			refused_r            <= 1'b0;
		end else begin
			if (prn_cmd_r && pr_r == pscc_pkg::PSCC_PR_IDLE && (!src_ok || halt)) refused_r <= 1'b1;
			else if (clr_jam_r) refused_r <= 1'b0;
			if (halt && pr_r != pscc_pkg::PSCC_PR_IDLE) begin
				pr_r                <= pscc_pkg::PSCC_PR_IDLE;
				main_motor_r        <= 1'b0;
				fuser_motor_r       <= 1'b0;
				cassette_pick_sol_r <= 1'b0;
				mp_pick_sol_r       <= 1'b0;
			end else begin
				case (pr_r)
					pscc_pkg::PSCC_PR_IDLE: begin
						if (prn_cmd_r && src_ok && !halt) begin
							pr_r                 <= (src_r == `PSCC_SRC_MP) ? pscc_pkg::PSCC_PR_PICK : pscc_pkg::PSCC_PR_LIFT;
							cassette_sel_lower_r <= cidx[0];
							main_motor_r         <= 1'b1;
							fuser_motor_r        <= 1'b1;
							mp_pick_sol_r        <= src_r == `PSCC_SRC_MP;
						end
					end
					pscc_pkg::PSCC_PR_LIFT: begin
						if (lf_r[cidx[0]] == pscc_pkg::PSCC_LF_UP) begin
							pr_r                <= pscc_pkg::PSCC_PR_PICK;
							cassette_pick_sol_r <= 1'b1;
						end
					end
					pscc_pkg::PSCC_PR_PICK: begin
						if (sol_exp) begin
							pr_r                <= pscc_pkg::PSCC_PR_FEED;
							cassette_pick_sol_r <= 1'b0;
							mp_pick_sol_r       <= 1'b0;
						end
					end
					pscc_pkg::PSCC_PR_FEED: begin
						if (path_q_r.fuser_exit_sensor && !path.fuser_exit_sensor) begin
							pr_r          <= pscc_pkg::PSCC_PR_IDLE;
							main_motor_r  <= 1'b0;
							fuser_motor_r <= 1'b0;
						end
					end
					default: pr_r <= pscc_pkg::PSCC_PR_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// jam detection: each timer runs while its sheet is awaited or held at a sensor, and fires once it is overdue

	logic                  pick_pend_r;
	logic                  fdly_pend_r;
	logic                  fstat_pend_r;
	logic                  tof_rise;
	logic                  fex_rise;
	logic [`PSCC_NJAM-1:0] jam_run;
	logic [`PSCC_NJAM-1:0] jam_hit;
	logic [31:0]           jam_lim [`PSCC_NJAM];

	assign tof_rise = path.top_of_page_sensor && !path_q_r.top_of_page_sensor;
	assign fex_rise = path.fuser_exit_sensor && !path_q_r.fuser_exit_sensor;
	assign jam_run[`PSCC_JAM_PICK_DLY]   = pick_pend_r;
	assign jam_run[`PSCC_JAM_PICK_STAT]  = path.top_of_page_sensor && printing;
	assign jam_run[`PSCC_JAM_FUSE_DLY]   = fdly_pend_r;
	assign jam_run[`PSCC_JAM_FUSE_STAT]  = fstat_pend_r;
	assign jam_run[`PSCC_JAM_WRAP]       = path.fuser_exit_sensor && printing;
	assign jam_run[`PSCC_JAM_DELIV_STAT] = path.delivery_sensor && printing;
	assign jam_lim[`PSCC_JAM_PICK_DLY]   = (src_r == `PSCC_SRC_MP) ? T_PICK_MP : cidx[0] ? T_PICK_LO : T_PICK_UP;
	assign jam_lim[`PSCC_JAM_PICK_STAT]  = T_STAT;
	assign jam_lim[`PSCC_JAM_FUSE_DLY]   = T_FDLY;
	assign jam_lim[`PSCC_JAM_FUSE_STAT]  = T_FSTAT;
	assign jam_lim[`PSCC_JAM_WRAP]       = T_WRAP;
	assign jam_lim[`PSCC_JAM_DELIV_STAT] = T_FSTAT;

	generate
		for (gi = 0; gi < `PSCC_NJAM; gi++) begin : g_jam
			pscc_timer u_jam (
				.clk     (clk),
				.reset   (reset),
				.run     (jam_run[gi]),
				.limit   (jam_lim[gi]),
				.expired (jam_hit[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pick_pend_r  <= 1'b0;
			fdly_pend_r  <= 1'b0;
			fstat_pend_r <= 1'b0;
		end else begin
			pick_pend_r  <= pr_r == pscc_pkg::PSCC_PR_PICK ? 1'b1 : (pick_pend_r && !tof_rise && printing);
			fdly_pend_r  <= tof_rise ? 1'b1 : (fdly_pend_r && !fex_rise && printing);
			fstat_pend_r <= tof_rise ? 1'b1 :
				(fstat_pend_r && !(path_q_r.fuser_exit_sensor && !path.fuser_exit_sensor) && printing);
		end
	end

	// a jam arriving with the clear stays set
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			jam_r      <= '0;
			jam_flag_r <= 1'b0;
		end else begin
			jam_r      <= jam_hit | (clr_jam_r ? '0 : jam_r);
			jam_flag_r <= |(jam_hit | (clr_jam_r ? '0 : jam_r));
		end
	end
endmodule : pscc_ctl

// ==== sim/pscc_ctl_props.sv ====
// checker on the controller ports: bus answer, tag link, halts, pickup gating
// assumes a bind to pscc_ctl and a single clock domain
module pscc_ctl_props (
	input wire logic clk, reset, avs_read, avs_write, avs_waitrequest,
	input wire pscc_pkg::pscc_tag_rsp_t tag_rsp,
	input wire logic tag_req_r, tag_we_r, main_motor_r, fuser_motor_r,
	input wire logic [7:0] tag_wdata_r,
	input wire logic jam_flag_r, cart_fault_r, mp_pick_sol_r, mp_tray_closed, mp_tray_paper_sensor,
	input wire logic [2:0] upper_length_switches
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_req_answer: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
		else $error("bus request not answered");
	a_tag_hold: assert property (tag_req_r && !tag_rsp.done |=> tag_req_r && $stable(tag_we_r) && $stable(tag_wdata_r))
		else $error("tag request changed before done");
	a_tag_drop: assert property (tag_req_r && tag_rsp.done |=> !tag_req_r)
		else $error("tag request held after done");
	a_fault_halt: assert property (cart_fault_r |-> ##[0:3] !main_motor_r)
		else $error("printing kept on after tag fault");
	a_jam_halt: assert property (jam_flag_r |-> ##[0:3] !main_motor_r)
		else $error("printing kept on after jam");
	a_motor_pair: assert property (main_motor_r == fuser_motor_r)
		else $error("main and fuser motors disagree");
	// tray one needs the upper cassette in place as well as its own paper
	a_mp_gate: assert property ($rose(mp_pick_sol_r) |-> $past(mp_tray_closed && mp_tray_paper_sensor
		&& (upper_length_switches[1] || upper_length_switches[0])))
		else $error("tray one pickup without its conditions");
endmodule : pscc_ctl_props

// ==== sim/pscc_tag_model.sv ====
// cartridge tag memory model: answers each request, alternating fast and slow
// assumes the controller holds req until done
module pscc_tag_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] wdata,
	output pscc_pkg::pscc_tag_rsp_t rsp,
	output int n_rd,
	output int n_wr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_r;
	logic [2:0] cnt_r;
	logic       slow_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{rsp, mem_r, cnt_r, slow_r, n_rd, n_wr} <= '0;
		end else begin
			rsp.done <= 1'b0;
			// data is only valid with done, so it shows junk elsewhere
			rsp.rdata <= ~mem_r;
			if (req && !rsp.done) begin
				if (cnt_r == (slow_r ? 3'h4 : 3'h0)) begin
					rsp.done <= 1'b1;
					rsp.rdata <= we ? wdata : mem_r;
					if (we) mem_r <= wdata;
					if (we) n_wr <= n_wr + 1;
					else n_rd <= n_rd + 1;
					cnt_r <= 3'h0;
					slow_r <= !slow_r;
				end else cnt_r <= cnt_r + 3'h1;
			end
		end
	end
endmodule : pscc_tag_model

// ==== sim/tb.sv ====
// testbench: bus tasks command the controller, a model answers tag accesses
// assumes the checker and tag model are compiled first
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest, cover_closed = 1;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hf;
	logic cartridge_presence_sensor = 1, mp_tray_paper_sensor = 1, mp_tray_closed = 1, cassette_media_ok = 1;
	logic upper_cassette_paper_sensor = 0, lower_cassette_paper_sensor = 1;
	logic upper_lifter_position_sensor = 1, lower_lifter_position_sensor = 1;
	logic [2:0] upper_length_switches = 3'h6, lower_length_switches = 3'h5;
	logic [2:0] upper_width_switches = 3'h4, lower_width_switches = 3'h4;
	pscc_pkg::pscc_path_t path = '0;
	pscc_pkg::pscc_tag_rsp_t tag_rsp;
	logic tag_req_r, tag_we_r, main_motor_r, fuser_motor_r, cassette_pick_sol_r, cassette_sel_lower_r;
	logic mp_pick_sol_r, jam_flag_r, cart_fault_r;
	logic [7:0] tag_wdata_r;
	logic [1:0] lift_raise_r, lift_lower_r;
	int n_mismatch = 0, check_count = 0, n_rd, n_wr;
	// width, length, expected size code
	logic [9:0] sz [6] = '{{3'h4, 3'h4, 4'h1}, {3'h4, 3'h6, 4'h2}, {3'h4, 3'h5, 4'h4},
		{3'h1, 3'h4, 4'h3}, {3'h1, 3'h5, 4'h4}, {3'h1, 3'h6, 4'h4}};
	always #10 clk = ~clk;
	pscc_ctl #(.T_PICK_MP(40), .T_TAG_WR(20), .T_SOL(20), .T_IDLE(2000)) pscc_ctl_i (.*);
	pscc_tag_model pscc_tag_model_i (.clk, .reset, .req(tag_req_r), .we(tag_we_r), .wdata(tag_wdata_r),
		.rsp(tag_rsp), .n_rd, .n_wr);
	////////////////////////////////////////////////////////////////////////////
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// one access, held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk);
		while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : acc
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////
	initial begin
		wt(3);
		reset <= 1'b0;
		wt(20);
		chk(n_rd, 1);
		cover_closed <= 1'b0;
		wt(5);
		cover_closed <= 1'b1;
		wt(20);
		chk(n_rd, 2);
		acc(1, 5'h00, 32'h1, q);
		wt(20);
		chk(n_rd, 3);
		$display("tag read test done");
		for (int i = 1; i >= 0; i--) begin
			{mp_tray_paper_sensor, upper_cassette_paper_sensor, lower_cassette_paper_sensor,
				cartridge_presence_sensor} <= i ? 4'h4 : 4'hb;
			wt(3);
			acc(0, 5'h08, 32'h0, q);
			chk(q[5:0], i ? 6'h32 : 6'h3d);
		end
		for (int i = 0; i < 6; i++) begin
			{upper_width_switches, upper_length_switches} <= sz[i][9:4];
			wt(3);
			acc(0, 5'h0c, 32'h0, q);
			chk(q[3:0], sz[i][3:0]);
		end
		$display("status and size test done");
		// tray one print with no paper ever reaching the top sensor
		acc(1, 5'h00, 32'h4, q);
		wt(5);
		chk(main_motor_r, 1);
		wt(80);
		acc(0, 5'h10, 32'h0, q);
		chk(q[0], 1);
		chk(main_motor_r, 0);
		chk(n_wr > 0, 1);
		acc(1, 5'h00, 32'h100, q);
		wt(3);
		acc(0, 5'h08, 32'h0, q);
		chk(q[6], 0);
		acc(1, 5'h00, 32'h24, q);
		wt(3);
		chk({cassette_sel_lower_r, cassette_pick_sol_r, main_motor_r}, 3'h7);
		$display("print and jam test done");
		// expect a check byte the tag does not hold
		acc(1, 5'h04, 32'h100, q);
		acc(1, 5'h00, 32'h21, q);
		wt(20);
		acc(0, 5'h08, 32'h0, q);
		chk({q[7], cart_fault_r, main_motor_r}, 3'h6);
		acc(1, 5'h00, 32'h200, q);
		wt(3);
		acc(0, 5'h08, 32'h0, q);
		chk(q[7], 0);
		$display("tag fault test done");
		finish_test();
	end
	initial begin
		wt(5000);
		n_mismatch++;
		finish_test();
	end
endmodule : tb
bind pscc_ctl pscc_ctl_props pscc_ctl_props_i (.*);
